// ==== rtl/cwt_pkg.sv ====
// Purpose: constants and types for the cyclic wake timer pair
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes: period and on-time codes are small selectors set by the host
// How it works
// - enabled wake timer interrupts in normal/stop mode
// - valid on-time write starts timer immediately
// - interrupt each on-phase start, except first
// - timer outputs routed to high-side switches
// - seven periods from 10 ms to 2 s
// - five on-times plus off-low and off-high
// - interrupt output driven low to signal wake
// - command error when on-time exceeds period
// - off settings set idle high-side level
package cwt_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 10; // on-time resolution step, 0.01 ms
  localparam int TICK_CYC = TICK_US * CLK_HZ / 1_000_000 / 10;
  localparam int NUM_HS = 4; // high-side switch outputs
  localparam int CNT_W = 32;
  localparam logic [1:0] MAP_NONE = 2'h0;
  localparam logic [1:0] MAP_T1 = 2'h1;
  localparam logic [1:0] MAP_T2 = 2'h2;
  // period codes, times in ms
  localparam logic [2:0] PER_10MS = 3'h0;
  localparam logic [2:0] PER_20MS = 3'h1;
  localparam logic [2:0] PER_50MS = 3'h2;
  localparam logic [2:0] PER_100MS = 3'h3;
  localparam logic [2:0] PER_200MS = 3'h4;
  localparam logic [2:0] PER_1S = 3'h5;
  localparam logic [2:0] PER_2S = 3'h6;
  // on-time codes, times in units of 0.1 ms
  localparam logic [2:0] ON_OFF_LOW = 3'h0;
  localparam logic [2:0] ON_0P1MS = 3'h1;
  localparam logic [2:0] ON_0P3MS = 3'h2;
  localparam logic [2:0] ON_1MS = 3'h3;
  localparam logic [2:0] ON_10MS = 3'h4;
  localparam logic [2:0] ON_20MS = 3'h5;
  localparam logic [2:0] ON_OFF_HIGH = 3'h6;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_PER_100US = CLK_HZ / 10000;
  typedef enum logic [1:0] {CWT_SB_NORMAL, CWT_SB_STOP, CWT_SB_SLEEP,
    CWT_SB_FAILSAFE} cwt_mode_t;
  typedef struct packed {
    logic wr; // one-cycle write strobe
    logic [2:0] period;
    logic [2:0] on_time;
  } cwt_setup_t;
endpackage : cwt_pkg

// ==== rtl/cwt_timer.sv ====
// Purpose: one periodic timer with period and on-time phases
// Assumes: setup strobe is one cycle wide
// Notes: period counter wraps; on-phase starts at count zero
`timescale 1ns/1ps
module cwt_timer #(
  parameter int CYC_MS = cwt_pkg::CYC_PER_MS, // clock cycles per ms
  parameter int CYC_100US = cwt_pkg::CYC_PER_100US // cycles per 0.1 ms
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire cwt_pkg::cwt_setup_t setup_in,
  output logic level_out,
  output logic phase_start_out,
  output logic running_out,
  output logic too_long_out
);
  import cwt_pkg::*;
  logic [2:0] per_r;
  logic [2:0] on_r;
  logic run_r;
  logic idle_high_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] per_cyc;
  logic [CNT_W-1:0] on_cyc;
  logic [CNT_W-1:0] new_per;
  logic [CNT_W-1:0] new_on;
  logic valid_on;

  function automatic logic [CNT_W-1:0] per_len(input logic [2:0] c);
    unique case (c)
      PER_10MS: per_len = CNT_W'(10 * CYC_MS);
      PER_20MS: per_len = CNT_W'(20 * CYC_MS);
      PER_50MS: per_len = CNT_W'(50 * CYC_MS);
      PER_100MS: per_len = CNT_W'(100 * CYC_MS);
      PER_200MS: per_len = CNT_W'(200 * CYC_MS);
      PER_1S: per_len = CNT_W'(1000 * CYC_MS);
      default: per_len = CNT_W'(2000 * CYC_MS);
    endcase
  endfunction : per_len

  function automatic logic [CNT_W-1:0] on_len(input logic [2:0] c);
    unique case (c)
      ON_0P1MS: on_len = CNT_W'(1 * CYC_100US);
      ON_0P3MS: on_len = CNT_W'(3 * CYC_100US);
      ON_1MS: on_len = CNT_W'(10 * CYC_100US);
      ON_10MS: on_len = CNT_W'(100 * CYC_100US);
      ON_20MS: on_len = CNT_W'(200 * CYC_100US);
      default: on_len = '0;
    endcase
  endfunction : on_len

  // length lookups from the internal clock
  assign per_cyc = per_len(per_r);
  assign on_cyc = on_len(on_r);
  assign new_per = per_len(setup_in.period);
  assign new_on = on_len(setup_in.on_time);
  // codes at or above off-high are off or reserved, never a start
  assign valid_on = (setup_in.on_time != ON_OFF_LOW) &&
    (setup_in.on_time < ON_OFF_HIGH);

  // setup capture; a valid on-time starts, an off code stops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      per_r <= PER_10MS;
      on_r <= ON_OFF_LOW;
      run_r <= 1'b0;
      idle_high_r <= 1'b0;
    end else if (setup_in.wr) begin
      per_r <= setup_in.period;
      on_r <= setup_in.on_time;
      run_r <= valid_on;
      if (setup_in.on_time == ON_OFF_HIGH) begin
        idle_high_r <= 1'b1;
      end else if (setup_in.on_time == ON_OFF_LOW) begin
        idle_high_r <= 1'b0;
      end
    end
  end

  // period counter restarts at zero on every setup write
  always_ff @(posedge clk_in) begin
    if (rst_in || setup_in.wr || !run_r) begin
      cnt_r <= '0;
    end else if (cnt_r == per_cyc - CNT_W'(1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // output level: on-phase high, idle level when stopped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      level_out <= 1'b0;
    end else if (!run_r) begin
      level_out <= idle_high_r;
    end else begin
      level_out <= (cnt_r < on_cyc);
    end
  end

  assign phase_start_out = run_r && (cnt_r == '0);
  assign running_out = run_r;
  // on-time longer than period flagged at write time
  assign too_long_out = setup_in.wr && (new_on > new_per);
endmodule : cwt_timer

// ==== rtl/cwt_top.sv ====
// Purpose: pair of periodic timers for cyclic wake and cyclic sense
// Assumes: host writes setups as one-cycle strobes; inputs synchronous
// Notes: interrupt pulse is one cycle low for each cycle in which a qualifying on-phase starts
`timescale 1ns/1ps
module cwt_top #(
  // time base; a simulation may shrink it so long periods run quickly
  parameter int CYC_MS = cwt_pkg::CYC_PER_MS,
  parameter int CYC_100US = cwt_pkg::CYC_PER_100US
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire cwt_pkg::cwt_mode_t mode_in,
  input wire cwt_pkg::cwt_setup_t first_periodic_timer_setup_in,
  input wire cwt_pkg::cwt_setup_t second_periodic_timer_setup_in,
  input wire logic [1:0] wake_source_control_in,
  input wire logic [2*cwt_pkg::NUM_HS-1:0] high_side_switch_map_a_in,
  input wire logic [2*cwt_pkg::NUM_HS-1:0] high_side_switch_map_b_in,
  input wire logic cmd_err_clr_in,
  output logic int_n_out,
  output logic cmd_err_out,
  output logic [cwt_pkg::NUM_HS-1:0] hs_timer_on_out,
  output logic [cwt_pkg::NUM_HS-1:0] hs_timer_sel_out,
  output logic [1:0] timer_level_out,
  output logic [1:0] timer_running_out
);
  import cwt_pkg::*;
  cwt_setup_t setup [2];
  logic [1:0] lvl;
  logic [1:0] start;
  logic [1:0] run;
  logic [1:0] long;
  logic [1:0] first_done_r;
  logic [1:0] fire;
  logic awake;

  assign setup[0] = first_periodic_timer_setup_in;
  assign setup[1] = second_periodic_timer_setup_in;

  // one timer instance per channel
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    cwt_timer #(
      .CYC_MS(CYC_MS),
      .CYC_100US(CYC_100US)
    ) u_tmr (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .setup_in(setup[i]),
      .level_out(lvl[i]),
      .phase_start_out(start[i]),
      .running_out(run[i]),
      .too_long_out(long[i])
    );
  end

  // first on-phase after a start is swallowed; a stop re-arms it
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_in || setup[i].wr || !run[i]) begin
        first_done_r[i] <= 1'b0;
      end else if (start[i]) begin
        first_done_r[i] <= 1'b1;
      end
    end
  end

  assign awake = (mode_in == CWT_SB_NORMAL) || (mode_in == CWT_SB_STOP);
  // wake sources gated by enable and mode
  assign fire = start & first_done_r & wake_source_control_in &
    {2{awake}};

  // active-low interrupt, one cycle per cycle in which either timer fires
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      int_n_out <= 1'b1;
    end else begin
      int_n_out <= ~(|fire);
    end
  end

  // sticky command error; a new error wins over the clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_err_out <= 1'b0;
    end else if (|long) begin
      cmd_err_out <= 1'b1;
    end else if (cmd_err_clr_in) begin
      cmd_err_out <= 1'b0;
    end
  end

  // high-side routing: map a selects timer per switch, map b enables only the select flag
  always_ff @(posedge clk_in) begin
    for (int h = 0; h < NUM_HS; h++) begin
      if (rst_in) begin
        hs_timer_on_out[h] <= 1'b0;
        hs_timer_sel_out[h] <= 1'b0;
      end else begin
        unique case (high_side_switch_map_a_in[2*h +: 2])
          MAP_T1: hs_timer_on_out[h] <= lvl[0];
          MAP_T2: hs_timer_on_out[h] <= lvl[1];
          default: hs_timer_on_out[h] <= 1'b0;
        endcase
        hs_timer_sel_out[h] <=
          (high_side_switch_map_a_in[2*h +: 2] != MAP_NONE) &&
          high_side_switch_map_b_in[2*h];
      end
    end
  end

  assign timer_level_out = lvl;
  assign timer_running_out = run;

  chk_irq_gated: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !awake |=> int_n_out)
    else $error("interrupt raised outside normal or stop mode");
  // the start right after a write must stay quiet unless timer 2 fires
  chk_first_quiet: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $past(setup[0].wr) && start[0] && !(start[1] && first_done_r[1])
    |=> int_n_out)
    else $error("interrupt on first on-phase");
  chk_irq_cause: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !int_n_out |-> $past(|(start & wake_source_control_in)))
    else $error("interrupt without on-phase start");
  chk_err_set: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (|long) |=> cmd_err_out)
    else $error("command error not set");
  chk_start_now: assert property (
    @(posedge clk_in) disable iff (rst_in)
    setup[0].wr && (setup[0].on_time inside {[ON_0P1MS:ON_20MS]})
    |=> run[0])
    else $error("timer did not start");
  chk_off_stop: assert property (
    @(posedge clk_in) disable iff (rst_in)
    setup[1].wr && setup[1].on_time == ON_OFF_HIGH |=> !run[1] ##1 lvl[1])
    else $error("off-high did not stop timer high");
  chk_map_route: assert property (
    @(posedge clk_in) disable iff (rst_in)
    high_side_switch_map_a_in[1:0] == MAP_T1 |=>
    hs_timer_on_out[0] == $past(lvl[0]))
    else $error("switch 0 not following first timer");
  chk_reset_off: assert property (
    @(posedge clk_in)
    rst_in |=> !run[0] && !run[1] && int_n_out)
    else $error("timers not off after reset");
endmodule : cwt_top

// ==== dv/cwt_host_model.sv ====
// Purpose: host side that counts wake interrupt pulses
// Assumes: interrupt line is active low and sampled on the clock rise
// Notes: a count, not a flag, so a stray extra pulse is seen too
`timescale 1ns/1ps
module cwt_host_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic int_n_in,
  output int irq_count_out
);
  // pulses are one cycle wide, so each low cycle is one interrupt
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_count_out <= 0;
    end else if (int_n_in === 1'b0) begin
      irq_count_out <= irq_count_out + 1;
    end
  end
endmodule : cwt_host_model

// ==== dv/cwt_top_bench.sv ====
// Purpose: self-checking bench for the cyclic wake timer pair
// Assumes: 100 MHz clock, inputs driven 1 ns after the rising edge
// Notes: time base shrunk to 100 cycles per ms so periods fit the run
`timescale 1ns/1ps
module cwt_top_bench;
  import cwt_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  cwt_mode_t mode = CWT_SB_STOP;
  cwt_setup_t s1 = '0;
  cwt_setup_t s2 = '0;
  logic [1:0] wake = 2'h0;
  logic [7:0] map_a = 8'h00;
  logic [7:0] map_b = 8'h00;
  logic err_clr = 1'b0;
  logic int_n, cmd_err;
  logic [3:0] hs_on, hs_sel;
  logic [1:0] lvl, run;
  int irqs, failures = 0, tests_run = 0, cycles = 0;
  always #5 clk_in = ~clk_in;
  // 100 cycles per ms: a 10 ms period is 1000 cycles, all ratios kept
  cwt_top #(.CYC_MS(100), .CYC_100US(10)) dut (.clk_in(clk_in),
    .rst_in(rst_in), .mode_in(mode),
    .first_periodic_timer_setup_in(s1),
    .second_periodic_timer_setup_in(s2),
    .wake_source_control_in(wake), .high_side_switch_map_a_in(map_a),
    .high_side_switch_map_b_in(map_b), .cmd_err_clr_in(err_clr),
    .int_n_out(int_n), .cmd_err_out(cmd_err), .hs_timer_on_out(hs_on),
    .hs_timer_sel_out(hs_sel), .timer_level_out(lvl),
    .timer_running_out(run));
  cwt_host_model host (.clk_in(clk_in), .rst_in(rst_in),
    .int_n_in(int_n), .irq_count_out(irqs));
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // step n edges, then settle past the drive delay
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  // one-cycle setup strobe; returns just after the taking edge
  task automatic wr_setup(input bit t2, input logic [2:0] per,
    input logic [2:0] on);
    if (t2) s2 = '{1'b1, per, on};
    else s1 = '{1'b1, per, on};
    tick(1);
    if (t2) s2.wr = 1'b0;
    else s1.wr = 1'b0;
  endtask : wr_setup
  task automatic summarize();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // hang guard well above the roughly 8070 cycles of the tests
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("ERROR timeout expected 0 seen %0d", cycles);
      summarize();
    end
  end
  initial begin
    tick(5);
    rst_in = 1'b0;
    chk("int_n", 8'h01, int_n);
    chk("run", 8'h00, run);
    chk("level", 8'h00, lvl);
    $display("test reset done");
    wr_setup(0, PER_10MS, ON_OFF_LOW);
    wake = 2'h3;
    map_a = 8'h09;
    map_b = 8'h05;
    tick(1);
    wr_setup(0, PER_10MS, ON_0P1MS);
    chk("run", 8'h01, run);
    tick(1);
    chk("level on", 8'h01, lvl);
    tick(9);
    chk("level end", 8'h01, lvl);
    chk("hs sel", 8'h03, hs_sel);
    chk("hs on", 8'h01, hs_on[0]);
    tick(1);
    chk("level off", 8'h00, lvl);
    tick(2);
    chk("hs off", 8'h00, hs_on[0]);
    chk("irqs", 8'h00, irqs[7:0]);
    // second on-phase starts 1000 cycles after the write
    tick(988);
    chk("int_n low", 8'h00, int_n);
    tick(1);
    chk("irqs", 8'h01, irqs[7:0]);
    tick(998);
    chk("int_n idle", 8'h01, int_n);
    tick(1);
    chk("int_n 10ms", 8'h00, int_n);
    tick(1);
    chk("irqs", 8'h02, irqs[7:0]);
    mode = CWT_SB_SLEEP;
    tick(1000);
    chk("irqs sleep", 8'h02, irqs[7:0]);
    mode = CWT_SB_NORMAL;
    wake = 2'h2;
    tick(1000);
    chk("irqs masked", 8'h02, irqs[7:0]);
    wake = 2'h3;
    tick(1000);
    chk("irqs normal", 8'h03, irqs[7:0]);
    $display("test cyclic wake done");
    wr_setup(1, PER_10MS, ON_OFF_HIGH);
    tick(2);
    chk("idle high", 8'h01, lvl[1]);
    chk("hs high", 8'h01, hs_on[1]);
    wr_setup(1, PER_10MS, 3'h7);
    tick(2);
    chk("code7", 8'h02, {lvl[1], run[1]});
    wr_setup(0, PER_10MS, ON_OFF_LOW);
    tick(1);
    chk("stop", 8'h00, {lvl[0], run[0]});
    // a restart after a stop must swallow its first phase again
    wr_setup(0, PER_10MS, ON_0P1MS);
    tick(3);
    chk("irqs rearm", 8'h03, irqs[7:0]);
    tick(1000);
    chk("irqs next", 8'h04, irqs[7:0]);
    wr_setup(0, PER_10MS, ON_OFF_LOW);
    $display("test off codes done");
    for (int p = 0; p < 7; p++) begin
      err_clr = 1'b1;
      tick(1);
      err_clr = 1'b0;
      tick(1);
      chk("err clr", 8'h00, cmd_err);
      wr_setup(1, p[2:0], ON_20MS);
      tick(2);
      chk("err", {7'h00, p == 0}, cmd_err);
    end
    // an error and a clear in one cycle: the error must stay
    err_clr = 1'b1;
    wr_setup(1, PER_10MS, ON_20MS);
    err_clr = 1'b0;
    tick(1);
    chk("err wins", 8'h01, cmd_err);
    chk("irqs", 8'h04, irqs[7:0]);
    wr_setup(1, PER_20MS, ON_1MS);
    tick(100);
    chk("level 1ms", 8'h01, lvl[1]);
    tick(1);
    chk("level 1ms end", 8'h00, lvl[1]);
    tick(1899);
    chk("int_n idle", 8'h01, int_n);
    tick(1);
    chk("int_n 20ms", 8'h00, int_n);
    tick(1);
    chk("irqs", 8'h05, irqs[7:0]);
    $display("test periods done");
    // reset in mid-run while timer 2 runs and the error is set
    rst_in = 1'b1;
    tick(2);
    rst_in = 1'b0;
    chk("reset run", 8'h00, {lvl, run});
    chk("reset err", 8'h00, cmd_err);
    tick(2);
    chk("reset hs", 8'h00, hs_on);
    chk("reset int_n", 8'h01, int_n);
    $display("test mid-run reset done");
    summarize();
  end
endmodule : cwt_top_bench
